// *** design/ctw_pkg.sv ***
package ctw_pkg;
  // ==========================================================
  // Register map (byte addresses on the internal bus)
  localparam logic [12:0] TIMER_CONTROL_STATUS_ADDR = 13'h0008;
  localparam logic [12:0] TIMER_COUNT_VALUE_ADDR = 13'h0009;
  localparam logic [12:0] WATCHDOG_CLEAR_ADDR = 13'h1FF0;
  // ==========================================================
  // Control/status and watchdog clear field positions
  localparam int OVF_FLAG_BIT = 7;
  localparam int PER_FLAG_BIT = 6;
  localparam int OVF_IRQ_EN_BIT = 5;
  localparam int PER_IRQ_EN_BIT = 4;
  localparam int OVF_CLR_BIT = 3;
  localparam int PER_CLR_BIT = 2;
  localparam int RATE_HI_BIT = 1;
  localparam int RATE_LO_BIT = 0;
  localparam int WDOG_CLR_BIT = 0;
  // ==========================================================
  // Reset values and chain geometry
  localparam logic [1:0] RATE_RESET = 2'h3;
  localparam int PRESCALE_BITS = 2;
  localparam int COUNT_BITS = 8;
  localparam int MID_BITS = 3;
  localparam int PER_BITS = 3;
  localparam int WDOG_BITS = 3;
  // The E/2^14 tap clock needs one stage beyond the three that follow
  // the overflow point, so the taps land on chain bits 13 to 16
  localparam int CHAIN_BITS = PRESCALE_BITS + COUNT_BITS + MID_BITS
    + 1 + PER_BITS;
  localparam int POR_CYCLES = 4064;
  localparam int POR_BITS = 12;
  localparam int WDOG_PULSE_CYCLES = 1;
  // Power-on state machine
  typedef enum logic [1:0] {CTW_POR_COUNT, CTW_POR_CLEAR, CTW_RUN}
    ctw_por_type;
endpackage : ctw_pkg

// *** design/ctw_core_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
module ctw_core_timer
#(
  // Build-time watchdog presence
  parameter bit WDOG_PRESENT = 1'b1
)
(
  input wire logic ref_clk,
  // Power-on reset, asynchronous, active low
  input wire logic rst_b,
  // External reset pin level (from outside, synchronised here)
  input wire logic extResetIn_b,
  // Reset pin open-drain: output value and enable (enable low = drive)
  output logic extResetOut,
  output logic extResetOe_b,
  // Internal reset to the rest of the device, active low
  output logic devReset_b,
  // Register access port
  input wire logic [12:0] busAddr,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic [7:0] busWdata,
  output logic [7:0] busRdata,
  // Single CPU interrupt request, also ends wait mode
  output logic timerIrq
);
  import ctw_pkg::*;

  // ==========================================================
  // Reset pin synchroniser (three stages, second and third agree)
  logic [2:0] pinSync_q;
  logic [2:0] pinSync_d;
  logic pinLevel_q;
  logic pinLevel_d;

  // Shift in the pin; accept a new level only when stages agree
  always_comb
  begin
    pinSync_d = {pinSync_q[1:0], extResetIn_b};
    pinLevel_d = pinLevel_q;
    if (pinSync_q[2] == pinSync_q[1])
    begin
      pinLevel_d = pinSync_q[2];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinSync_q <= 3'h7;
      pinLevel_q <= 1'b1;
    end
    else
    begin
      pinSync_q <= pinSync_d;
      pinLevel_q <= pinLevel_d;
    end
  end

  // ==========================================================
  // Power-on sequencing and watchdog reset pulse
  ctw_por_type porState_q, porState_d;
  logic [POR_BITS-1:0] porCount_q, porCount_d;
  logic wdogPulse_q, wdogPulse_d; // Pin pull while time-out stands
  logic wdogTimeout;              // Final stage wraps
  logic chainClear;               // Whole chain held cleared
  logic devInReset;

  // Count out power-on time, then clear chain once more
  always_comb
  begin
    porState_d = porState_q;
    porCount_d = porCount_q;
    case (porState_q)
      CTW_POR_COUNT:
      begin
        porCount_d = porCount_q + POR_BITS'(1);
        if (porCount_q == POR_BITS'(POR_CYCLES - 1))
        begin
          porState_d = CTW_POR_CLEAR;
        end
      end
      CTW_POR_CLEAR:
      begin
        porState_d = CTW_RUN;
      end
      CTW_RUN:
      begin
        porState_d = CTW_RUN;
      end
      default:
      begin
        porState_d = CTW_POR_COUNT;
      end
    endcase
    // Pull the pin for one bus clock on time-out
    wdogPulse_d = wdogTimeout;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      porState_q <= CTW_POR_COUNT;
      porCount_q <= '0;
      wdogPulse_q <= 1'b0;
    end
    else
    begin
      porState_q <= porState_d;
      porCount_q <= porCount_d;
      wdogPulse_q <= wdogPulse_d;
    end
  end

  // External reset (or our own pull) clears the chain
  assign devInReset = (porState_q != CTW_RUN) || !pinLevel_q
    || wdogPulse_q;
  // Chain runs during the power-on count, cleared at its end
  assign chainClear = (porState_q == CTW_POR_CLEAR)
    || ((porState_q == CTW_RUN) && devInReset);
  assign devReset_b = !devInReset;
  assign extResetOut = 1'b0;
  assign extResetOe_b = !wdogPulse_q;

  // ==========================================================
  // Ripple chain modelled as one synchronous binary counter
  logic [CHAIN_BITS-1:0] chain_q, chain_d;
  logic [WDOG_BITS-1:0] wdog_q, wdog_d;
  logic [1:0] rate_q, rate_d;
  logic [PER_BITS:0] tapBits;
  logic tapNow, tapPrev_q, tapPrev_d;
  logic tapRise;
  logic ovfEvent;
  logic regWrCs, regWrWd;

  assign regWrCs = busWrite && !devInReset
    && (busAddr == TIMER_CONTROL_STATUS_ADDR);
  assign regWrWd = busWrite && !devInReset
    && (busAddr == WATCHDOG_CLEAR_ADDR);

  // Stage outputs E/2^14 .. E/2^17 form the tap choices
  assign tapBits = chain_q[CHAIN_BITS-1:CHAIN_BITS-PER_BITS-1];
  // Rate code indexes the tap directly
  assign tapNow = tapBits[rate_q];
  assign tapRise = tapNow && !tapPrev_q;
  // Wrap of the 8-bit stage, once per 1024 bus clocks
  assign ovfEvent = (chain_q[PRESCALE_BITS+COUNT_BITS-1:0]
    == {(PRESCALE_BITS+COUNT_BITS){1'b1}});
  // Eight tap rises bring the watchdog to time-out
  assign wdogTimeout = WDOG_PRESENT && tapRise && (wdog_q == '1)
    && (porState_q == CTW_RUN);

  // Every bus clock advances the whole chain, except while chainClear holds it at zero
  always_comb
  begin
    chain_d = chain_q + CHAIN_BITS'(1);
    tapPrev_d = tapNow;
    wdog_d = wdog_q;
    rate_d = rate_q;
    // Rate change takes effect at once, unguarded
    if (regWrCs)
    begin
      rate_d = busWdata[RATE_HI_BIT:RATE_LO_BIT];
    end
    // No wait or hold input can freeze the watchdog
    if (tapRise)
    begin
      wdog_d = wdog_q + WDOG_BITS'(1);
    end
    // Zero in bit 0 clears only the final stage
    if (regWrWd && !busWdata[WDOG_CLR_BIT])
    begin
      wdog_d = '0;
    end
    if (chainClear)
    begin
      chain_d = '0;
      wdog_d = '0;
      // Forget the tap level so a cleared chain gives no false rise
      tapPrev_d = 1'b0;
    end
    if (!WDOG_PRESENT)
    begin
      wdog_d = '0;
    end
    if (devInReset)
    begin
      rate_d = RATE_RESET;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      chain_q <= '0;
      wdog_q <= '0;
      rate_q <= RATE_RESET;
      tapPrev_q <= 1'b0;
    end
    else
    begin
      chain_q <= chain_d;
      wdog_q <= wdog_d;
      rate_q <= rate_d;
      tapPrev_q <= tapPrev_d;
    end
  end

  // ==========================================================
  // Flags and enables
  logic ovfFlag_q, ovfFlag_d, perFlag_q, perFlag_d;
  logic ovfEn_q, ovfEn_d, perEn_q, perEn_d;

  // Set beats clear when both land together
  always_comb
  begin
    ovfFlag_d = ovfFlag_q;
    perFlag_d = perFlag_q;
    ovfEn_d = ovfEn_q;
    perEn_d = perEn_q;
    if (regWrCs)
    begin
      ovfEn_d = busWdata[OVF_IRQ_EN_BIT];
      perEn_d = busWdata[PER_IRQ_EN_BIT];
      // Only a one clears the overflow flag
      if (busWdata[OVF_CLR_BIT])
      begin
        ovfFlag_d = 1'b0;
      end
      // Only a one clears the periodic flag
      if (busWdata[PER_CLR_BIT])
      begin
        perFlag_d = 1'b0;
      end
    end
    // Wrap sets the flag; the flag bit ignores writes
    if (ovfEvent && !chainClear)
    begin
      ovfFlag_d = 1'b1;
    end
    // Selected tap going high sets the flag
    if (tapRise && !chainClear)
    begin
      perFlag_d = 1'b1;
    end
    if (devInReset)
    begin
      ovfFlag_d = 1'b0;
      perFlag_d = 1'b0;
      ovfEn_d = 1'b0;
      perEn_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ovfFlag_q <= 1'b0;
      perFlag_q <= 1'b0;
      ovfEn_q <= 1'b0;
      perEn_q <= 1'b0;
    end
    else
    begin
      ovfFlag_q <= ovfFlag_d;
      perFlag_q <= perFlag_d;
      ovfEn_q <= ovfEn_d;
      perEn_q <= perEn_d;
    end
  end

  // One request from both enabled sources
  assign timerIrq = (ovfFlag_q && ovfEn_q) || (perFlag_q && perEn_q);

  // ==========================================================
  // Read mux; clear bits always read zero, unmapped reads zero
  always_comb
  begin
    busRdata = 8'h00;
    if (busRead && busAddr == TIMER_CONTROL_STATUS_ADDR)
    begin
      busRdata[OVF_FLAG_BIT] = ovfFlag_q;
      busRdata[PER_FLAG_BIT] = perFlag_q;
      busRdata[OVF_IRQ_EN_BIT] = ovfEn_q;
      busRdata[PER_IRQ_EN_BIT] = perEn_q;
      busRdata[RATE_HI_BIT:RATE_LO_BIT] = rate_q;
    end
    else if (busRead && busAddr == TIMER_COUNT_VALUE_ADDR)
    begin
      busRdata = chain_q[PRESCALE_BITS+COUNT_BITS-1:PRESCALE_BITS];
    end
  end
endmodule // ctw_core_timer
`default_nettype wire

// *** test/ctw_core_timer_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module ctw_core_timer_asserts
  import ctw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic extResetIn_b,
  input wire logic extResetOut,
  input wire logic extResetOe_b,
  input wire logic devReset_b,
  input wire logic [12:0] busAddr,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic [7:0] busWdata,
  input wire logic [7:0] busRdata,
  input wire logic timerIrq
);
  // ==========================================
  // Decoded accesses, only while out of reset
  logic csRd, csWr, cntRd;
  assign csRd = busRead && busAddr == TIMER_CONTROL_STATUS_ADDR && devReset_b;
  assign csWr = busWrite && busAddr == TIMER_CONTROL_STATUS_ADDR && devReset_b;
  assign cntRd = busRead && busAddr == TIMER_COUNT_VALUE_ADDR && devReset_b;
  // Cycles from reset release to first run
  logic [12:0] porCnt_q, porCnt_d;
  logic porSeen_q, porSeen_d;
  always_comb
  begin
    porCnt_d = porSeen_q ? porCnt_q : porCnt_q + 13'h1;
    porSeen_d = porSeen_q | devReset_b;
  end
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      porCnt_q <= 13'h0;
      porSeen_q <= 1'b0;
    end
    else
    begin
      porCnt_q <= porCnt_d;
      porSeen_q <= porSeen_d;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================
  // Checks
  chk_pin_low:
    assert property (extResetOut == 1'b0) else $error("pin value high");
  chk_pull_pulse:
    assert property ($fell(extResetOe_b) |=> extResetOe_b)
    else $error("pin pull too long");
  chk_pull_resets:
    assert property (!extResetOe_b |-> ##[0:4] !devReset_b)
    else $error("no reset after pull");
  chk_ext_clear:
    assert property (!extResetIn_b [*5] |-> !devReset_b)
    else $error("pin reset ignored");
  chk_por_delay:
    assert property ($rose(devReset_b) && !porSeen_q |->
      porCnt_q >= 13'hFDE && porCnt_q <= 13'hFEB)
    else $error("power-on delay wrong");
  chk_clr_zero:
    assert property (csRd |-> busRdata[3:2] == 2'h0)
    else $error("clear bits read one");
  chk_ctrl_echo:
    assert property (csWr ##1 csRd |-> {busRdata[5:4], busRdata[1:0]} ==
      $past({busWdata[5:4], busWdata[1:0]})) else $error("control lost");
  chk_ovf_clear:
    assert property (csWr && busWdata[3] ##1 csRd |-> !busRdata[7])
    else $error("overflow flag kept");
  chk_irq_or:
    assert property (csRd |-> timerIrq == (busRdata[7] && busRdata[5]
      || busRdata[6] && busRdata[4])) else $error("irq mismatch");
  chk_count_live:
    assert property (cntRd [*5] |-> busRdata == $past(busRdata, 4) + 8'h01)
    else $error("count not live");
  cover property (csWr && busWdata[3]);
  cover property ($rose(devReset_b));
  cover property (cntRd [*5]);
endmodule // ctw_core_timer_asserts
bind ctw_core_timer ctw_core_timer_asserts u_chk (.ref_clk, .rst_b,
  .extResetIn_b, .extResetOut, .extResetOe_b, .devReset_b, .busAddr,
  .busWrite, .busRead, .busWdata, .busRdata, .timerIrq);
`default_nettype wire

// *** test/ctw_core_timer_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module ctw_core_timer_tb_top;
  import ctw_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0, extResetIn_b = 1'b1;
  logic busWrite = 1'b0, busRead = 1'b0, devReset_b, timerIrq;
  logic [12:0] busAddr = 13'h0;
  logic [7:0] busWdata = 8'h0, busRdata, v, c0;
  int numErrors = 0, checks = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  ctw_core_timer DUT (.ref_clk, .rst_b, .extResetIn_b, .extResetOut(),
    .extResetOe_b(), .devReset_b, .busAddr, .busWrite, .busRead,
    .busWdata, .busRdata, .timerIrq);
  // ==========================================
  // Bus tasks, entered and left at a falling edge
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    busAddr = a;
    busWdata = d;
    {busWrite, busRead} = 2'b10;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    busAddr = a;
    {busWrite, busRead} = 2'b01;
    @(posedge ref_clk);
    d = busRdata;
    @(negedge ref_clk);
  endtask
  task automatic idle(input int n);
    {busWrite, busRead} = 2'b00;
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic check(input string nm, input logic [7:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      numErrors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdChk(input logic [12:0] a, input logic [7:0] e);
    rd(a, v);
    check("reg", v, e);
  endtask
  // Bounded wait for the device to leave reset
  task automatic waitRun();
    repeat (5000) if (devReset_b !== 1'b1) @(negedge ref_clk);
    check("run", {7'h0, devReset_b}, 8'h01);
  endtask
  task automatic tallyAndFinish();
    $display("checks %0d errors %0d", checks, numErrors);
    if (numErrors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Cut a hang short; the full run needs about 20600 cycles
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      numErrors++;
      tallyAndFinish();
    end
  end
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (5) @(negedge ref_clk);
    rst_b = 1'b1;
    waitRun();
    rdChk(TIMER_CONTROL_STATUS_ADDR, 8'h03);
    rdChk(13'h000A, 8'h00);
    wr(TIMER_CONTROL_STATUS_ADDR, 8'hFC);
    rdChk(TIMER_CONTROL_STATUS_ADDR, 8'h30);
    check("irq", {7'h0, timerIrq}, 8'h00);
    // Held read of the count: one step per four bus clocks
    rd(TIMER_COUNT_VALUE_ADDR, c0);
    repeat (4) rd(TIMER_COUNT_VALUE_ADDR, v);
    check("count", v, c0 + 8'h01);
    idle(1100);
    rdChk(TIMER_CONTROL_STATUS_ADDR, 8'hB0);
    check("irq", {7'h0, timerIrq}, 8'h01);
    wr(TIMER_CONTROL_STATUS_ADDR, 8'h38);
    rdChk(TIMER_CONTROL_STATUS_ADDR, 8'h30);
    wr(TIMER_CONTROL_STATUS_ADDR, 8'h10);
    wr(WATCHDOG_CLEAR_ADDR, 8'h00);
    idle(15400);
    rdChk(TIMER_CONTROL_STATUS_ADDR, 8'hD0);
    check("irq", {7'h0, timerIrq}, 8'h01);
    wr(TIMER_CONTROL_STATUS_ADDR, 8'h14);
    rdChk(TIMER_CONTROL_STATUS_ADDR, 8'h90);
    check("irq", {7'h0, timerIrq}, 8'h00);
    extResetIn_b = 1'b0;
    idle(8);
    check("pinreset", {7'h0, devReset_b}, 8'h00);
    extResetIn_b = 1'b1;
    waitRun();
    rdChk(TIMER_CONTROL_STATUS_ADDR, 8'h03);
    idle(2);
    tallyAndFinish();
  end
endmodule // ctw_core_timer_tb_top
`default_nettype wire
